/* File: pwrc_map.svh */
// register offsets, field positions, reset values and bus answer codes for the power monitor block
`ifndef PWRC_MAP_SVH
`define PWRC_MAP_SVH

// byte addresses of the two control registers
`define PWRC_CTRL_ONE_ADDR   12'h000
`define PWRC_CTRL_TWO_ADDR   12'h004

// control one field positions
`define PWRC_F_WARN_FLAG     7
`define PWRC_F_WARN_ACK      6
`define PWRC_F_WARN_IE       5
`define PWRC_F_DET_RE        4
`define PWRC_F_DET_SE        3
`define PWRC_F_DET_EN        2
`define PWRC_F_BG_EN         0

// control two field positions
`define PWRC_F_DET_VSEL      5
`define PWRC_F_WARN_VSEL     4
`define PWRC_F_PD_FLAG       3
`define PWRC_F_PD_ACK        2
`define PWRC_F_PD_CTRL       0

// reset values of the writable fields
`define PWRC_RST_WARN_IE     1'h0
`define PWRC_RST_DET_RE      1'h1
`define PWRC_RST_DET_SE      1'h1
`define PWRC_RST_DET_EN      1'h1
`define PWRC_RST_BG_EN       1'h0
`define PWRC_RST_DET_VSEL    1'h0
`define PWRC_RST_WARN_VSEL   1'h0
`define PWRC_RST_PD_CTRL     1'h0

// bus answer codes
`define PWRC_RESP_OKAY       2'h0
`define PWRC_RESP_SLVERR     2'h2

`endif

/* File: pwrc_pkg.sv */
// types shared by the power monitor block
package pwrc_pkg;
   // write-once lock index
   typedef enum {
      PWRC_LK_DET_RE,
      PWRC_LK_DET_SE,
      PWRC_LK_DET_EN,
      PWRC_LK_DET_VSEL,
      PWRC_LK_PD_CTRL,
      PWRC_LK_NUM
   } pwrc_lock_t;

   // selected warning threshold, detect select on top
   typedef enum logic [1:0] {
      PWRC_WARN_LVL0,
      PWRC_WARN_LVL1,
      PWRC_WARN_LVL2,
      PWRC_WARN_LVL3
   } pwrc_warn_lvl_t;

   // bus slave phase
   typedef enum {
      PWRC_BUS_IDLE,
      PWRC_BUS_RESP
   } pwrc_bus_state_t;
endpackage

/* File: pwrc_regs_if.sv */
// carrier between the bus slave and the register core
`timescale 1ns/1ps
`default_nettype none
interface pwrc_regs_if;
   logic       wr_one;     // write strobe, register one
   logic       wr_two;     // write strobe, register two
   logic [7:0] wdata;      // write data low byte
   logic [7:0] rd_one;     // read value register one
   logic [7:0] rd_two;     // read value register two

   // bus side drives strobes and reads values
   modport bus  (output wr_one, output wr_two, output wdata, input rd_one, input rd_two);
   // core side takes strobes and offers values
   modport core (input wr_one, input wr_two, input wdata, output rd_one, output rd_two);
endinterface
`default_nettype wire

/* File: pwrc_axil.sv */
// axi4-lite slave front end for the power monitor registers
`timescale 1ns/1ps
`default_nettype none
module pwrc_axil
   import pwrc_pkg::*;
#(
   parameter int ADDR_W = 12     // address width
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   pwrc_regs_if.bus               regs
);
   `include "pwrc_map.svh"

   // all slave state in one record
   typedef struct packed {
      logic              aw_held;  // write address captured
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;   // write data captured
      logic [7:0]        w_byte;
      logic              w_lane;   // low byte lane enabled
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
   } pwrc_axi_st_t;

   pwrc_axi_st_t st, next_st;
   logic         do_wr;            // both halves of a write present

   // address decode: 0 none, 1 reg one, 2 reg two
   function automatic logic [1:0] dec(input logic [ADDR_W-1:0] a);
      if (a == `PWRC_CTRL_ONE_ADDR) begin
         dec = 2'h1;
      end else if (a == `PWRC_CTRL_TWO_ADDR) begin
         dec = 2'h2;
      end else begin
         dec = 2'h0;
      end
   endfunction

   // channel readies wait until the previous answer is gone
   assign awready = !st.aw_held && !st.bvalid;
   assign wready  = !st.w_held && !st.bvalid;
   assign arready = !st.rvalid;
   assign do_wr   = st.aw_held && st.w_held && !st.bvalid;
   assign bvalid  = st.bvalid;
   assign bresp   = st.bresp;
   assign rvalid  = st.rvalid;
   assign rresp   = st.rresp;
   assign rdata   = st.rdata;

   // strobes only when a low lane is written; other lanes hold nothing
   assign regs.wr_one = do_wr && st.w_lane && (dec(st.aw_addr) == 2'h1);
   assign regs.wr_two = do_wr && st.w_lane && (dec(st.aw_addr) == 2'h2);
   assign regs.wdata  = st.w_byte;

   // next slave state
   always_comb begin
      next_st = st;
      if (awvalid && awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_st.w_held = 1'b1;
         next_st.w_byte = wdata[7:0];
         next_st.w_lane = wstrb[0];
      end
      // write completes: answer, unmapped gives slverr
      if (do_wr) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = (dec(st.aw_addr) == 2'h0) ? `PWRC_RESP_SLVERR : `PWRC_RESP_OKAY;
      end else if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      // read taken: data ready next cycle
      if (arvalid && arready) begin
         next_st.rvalid = 1'b1;
         if (dec(araddr) == 2'h1) begin
            next_st.rdata = {24'h000000, regs.rd_one};
            next_st.rresp = `PWRC_RESP_OKAY;
         end else if (dec(araddr) == 2'h2) begin
            next_st.rdata = {24'h000000, regs.rd_two};
            next_st.rresp = `PWRC_RESP_OKAY;
         end else begin
            next_st.rdata = 32'h00000000;
            next_st.rresp = `PWRC_RESP_SLVERR;
         end
      end else if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   // register the slave record
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

/* File: pwrc_top.sv */
// low-voltage supervision and stop-mode power control registers
// Function
// [RL1] warning flag sets on low supply, sticky
// [RL2] acknowledge clears flag only when supply recovered
// [RL3] interrupt enable requests interrupt while flag set
// [RL4] detect reset enable forces reset on detect
// [RL5] detect stop enable keeps detect in stop
// [RL6] detect enable gates detect, reset, stop
// [RL7] write-once bits take first write only
// [RL8] bandgap enable turns on reference buffer
// [RL9] detect select picks trip point and range
// [RL10] warning select picks threshold within range
// [RL11] both selects decode four warning thresholds
// [RL12] recovery flag reads one after power down
// [RL13] power down acknowledge clears recovery flag
// [RL14] power down control picks stop mode
// [RL15] software acknowledges recovery before touching pins
// [RL16] unimplemented bits read zero, ignore writes
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pwrc_top
   import pwrc_pkg::*;
#(
   parameter int ADDR_W = 12                   // bus address width
) (
   input  wire logic              CLK_IN,            // 10 MHz bus clock
   input  wire logic              RST_IN,            // synchronous reset, high
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] S_AWADDR_IN,
   input  wire logic              S_AWVALID_IN,
   output logic                   S_AWREADY_OUT,
   input  wire logic [31:0]       S_WDATA_IN,
   input  wire logic [3:0]        S_WSTRB_IN,
   input  wire logic              S_WVALID_IN,
   output logic                   S_WREADY_OUT,
   output logic [1:0]             S_BRESP_OUT,
   output logic                   S_BVALID_OUT,
   input  wire logic              S_BREADY_IN,
   input  wire logic [ADDR_W-1:0] S_ARADDR_IN,
   input  wire logic              S_ARVALID_IN,
   output logic                   S_ARREADY_OUT,
   output logic [31:0]            S_RDATA_OUT,
   output logic [1:0]             S_RRESP_OUT,
   output logic                   S_RVALID_OUT,
   input  wire logic              S_RREADY_IN,
   // analog comparator levels, asynchronous
   input  wire logic              WARN_BELOW_IN,     // supply under warning trip
   input  wire logic              DETECT_BELOW_IN,   // supply under detect trip
   // power state from the stop controller
   input  wire logic              STOP_ACTIVE_IN,    // device is in stop
   input  wire logic              PD_RECOVERED_IN,   // pulse: woke from partial power down
   // outputs to analog and system
   output logic                   WARN_IRQ_OUT,      // warning interrupt request
   output logic                   DETECT_RESET_OUT,  // request full device reset
   output logic                   DETECT_ON_OUT,     // detect comparator powered
   output logic [1:0]             WARN_LEVEL_OUT,    // warning threshold code
   output logic                   DETECT_LEVEL_OUT,  // detect threshold select
   output logic                   BANDGAP_BUF_OUT,   // bandgap buffer on
   output logic                   PD_STOP_SEL_OUT    // 1 partial power down stop
);
   `include "pwrc_map.svh"

   // all core state in one record
   typedef struct packed {
      logic [1:0]             warn_sync;   // warning comparator sync
      logic [1:0]             det_sync;    // detect comparator sync
      logic [1:0]             pd_sync;     // recovery event sync
      logic                   pd_seen;     // previous synced recovery level
      logic                   warning_flag;
      logic                   warning_interrupt_enable;
      logic                   detect_reset_enable;
      logic                   detect_stop_enable;
      logic                   detect_enable;
      logic                   bandgap_buffer_enable;
      logic                   detect_voltage_select;
      logic                   warning_voltage_select;
      logic                   power_down_recovered_flag;
      logic                   power_down_control;
      logic [PWRC_LK_NUM-1:0] locked;      // write-once bits already written
      logic                   det_reset;   // registered reset request
      logic                   det_on;      // registered detect power
      logic [1:0]             warn_lvl;
   } pwrc_core_st_t;

   pwrc_core_st_t st, next_st;
   pwrc_regs_if   regs ();

   logic warn_now;      // synced warning level
   logic det_now;       // synced detect level
   logic pd_event;      // one-cycle recovery event
   logic det_active;    // detect logic live right now
   logic [7:0] wd;      // written byte

   // write-once update: keep value once locked
   function automatic logic wonce(input logic cur, input logic lk, input logic wr,
                                  input logic val);
      wonce = (wr && !lk) ? val : cur;
   endfunction

   // bus front end
   pwrc_axil #(
      .ADDR_W (ADDR_W)
   ) u_axil (
      .clk     (CLK_IN),
      .rst     (RST_IN),
      .awaddr  (S_AWADDR_IN),
      .awvalid (S_AWVALID_IN),
      .awready (S_AWREADY_OUT),
      .wdata   (S_WDATA_IN),
      .wstrb   (S_WSTRB_IN),
      .wvalid  (S_WVALID_IN),
      .wready  (S_WREADY_OUT),
      .bresp   (S_BRESP_OUT),
      .bvalid  (S_BVALID_OUT),
      .bready  (S_BREADY_IN),
      .araddr  (S_ARADDR_IN),
      .arvalid (S_ARVALID_IN),
      .arready (S_ARREADY_OUT),
      .rdata   (S_RDATA_OUT),
      .rresp   (S_RRESP_OUT),
      .rvalid  (S_RVALID_OUT),
      .rready  (S_RREADY_IN),
      .regs    (regs.bus)
   );

   // only second sync stages are read
   assign warn_now = st.warn_sync[1];
   assign det_now  = st.det_sync[1];
   assign pd_event = st.pd_sync[1] && !st.pd_seen;
   assign wd       = regs.wdata;

   // [RL5] stop gating of detect
   // stopped detect only runs when stop enable is set
   assign det_active = st.detect_enable && (!STOP_ACTIVE_IN || st.detect_stop_enable);

   // read views, unused positions zero
   always_comb begin
      regs.rd_one = 8'h00;
      regs.rd_two = 8'h00;
      // [RL16] zero unimplemented bits
      regs.rd_one[`PWRC_F_WARN_FLAG] = st.warning_flag;
      regs.rd_one[`PWRC_F_WARN_IE]   = st.warning_interrupt_enable;
      regs.rd_one[`PWRC_F_DET_RE]    = st.detect_reset_enable;
      regs.rd_one[`PWRC_F_DET_SE]    = st.detect_stop_enable;
      regs.rd_one[`PWRC_F_DET_EN]    = st.detect_enable;
      regs.rd_one[`PWRC_F_BG_EN]     = st.bandgap_buffer_enable;
      regs.rd_two[`PWRC_F_DET_VSEL]  = st.detect_voltage_select;
      regs.rd_two[`PWRC_F_WARN_VSEL] = st.warning_voltage_select;
      // [RL12] recovery flag readable
      regs.rd_two[`PWRC_F_PD_FLAG]   = st.power_down_recovered_flag;
      regs.rd_two[`PWRC_F_PD_CTRL]   = st.power_down_control;
   end

   // next core state
   always_comb begin
      next_st = st;
      // two-stage synchronisers for pins
      next_st.warn_sync = {st.warn_sync[0], WARN_BELOW_IN};
      next_st.det_sync  = {st.det_sync[0], DETECT_BELOW_IN};
      next_st.pd_sync   = {st.pd_sync[0], PD_RECOVERED_IN};
      next_st.pd_seen   = st.pd_sync[1];

      // [RL2] acknowledge only if warning gone
      if (regs.wr_one && wd[`PWRC_F_WARN_ACK] && !warn_now) begin
         next_st.warning_flag = 1'b0;
      end
      // [RL1] sticky set, wins over acknowledge
      if (warn_now) begin
         next_st.warning_flag = 1'b1;
      end

      // register one writes
      if (regs.wr_one) begin
         next_st.warning_interrupt_enable = wd[`PWRC_F_WARN_IE];
         // [RL8] bandgap buffer control
         next_st.bandgap_buffer_enable    = wd[`PWRC_F_BG_EN];
         // [RL7] write-once fields lock
         next_st.detect_reset_enable = wonce(st.detect_reset_enable,
            st.locked[PWRC_LK_DET_RE], 1'b1, wd[`PWRC_F_DET_RE]);
         next_st.detect_stop_enable  = wonce(st.detect_stop_enable,
            st.locked[PWRC_LK_DET_SE], 1'b1, wd[`PWRC_F_DET_SE]);
         next_st.detect_enable       = wonce(st.detect_enable,
            st.locked[PWRC_LK_DET_EN], 1'b1, wd[`PWRC_F_DET_EN]);
         next_st.locked[PWRC_LK_DET_RE] = 1'b1;
         next_st.locked[PWRC_LK_DET_SE] = 1'b1;
         next_st.locked[PWRC_LK_DET_EN] = 1'b1;
      end

      // register two writes
      if (regs.wr_two) begin
         // [RL10] warning select freely writable
         next_st.warning_voltage_select = wd[`PWRC_F_WARN_VSEL];
         // [RL9] detect select write-once
         next_st.detect_voltage_select = wonce(st.detect_voltage_select,
            st.locked[PWRC_LK_DET_VSEL], 1'b1, wd[`PWRC_F_DET_VSEL]);
         // [RL14] stop mode select write-once
         next_st.power_down_control = wonce(st.power_down_control,
            st.locked[PWRC_LK_PD_CTRL], 1'b1, wd[`PWRC_F_PD_CTRL]);
         next_st.locked[PWRC_LK_DET_VSEL] = 1'b1;
         next_st.locked[PWRC_LK_PD_CTRL]  = 1'b1;
         // [RL13] acknowledge clears recovery flag
         if (wd[`PWRC_F_PD_ACK]) begin
            next_st.power_down_recovered_flag = 1'b0;
         end
      end
      // [RL12] recovery event sets, wins over clear
      if (pd_event) begin
         next_st.power_down_recovered_flag = 1'b1;
      end

      // [RL4] reset only when enabled and detect live
      // [RL6] detect enable gates reset request
      next_st.det_reset = det_active && st.detect_reset_enable && det_now;
      next_st.det_on    = det_active;
      // [RL11] four warning thresholds from both selects
      next_st.warn_lvl  = {next_st.detect_voltage_select, next_st.warning_voltage_select};
   end

   // register the core record
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         st                          <= '0;
         st.warning_interrupt_enable <= `PWRC_RST_WARN_IE;
         st.detect_reset_enable      <= `PWRC_RST_DET_RE;
         st.detect_stop_enable       <= `PWRC_RST_DET_SE;
         st.detect_enable            <= `PWRC_RST_DET_EN;
         st.bandgap_buffer_enable    <= `PWRC_RST_BG_EN;
         st.detect_voltage_select    <= `PWRC_RST_DET_VSEL;
         st.warning_voltage_select   <= `PWRC_RST_WARN_VSEL;
         st.power_down_control       <= `PWRC_RST_PD_CTRL;
      end else begin
         st <= next_st;
      end
   end

   // [RL3] interrupt follows flag when enabled
   assign WARN_IRQ_OUT     = st.warning_flag && st.warning_interrupt_enable;
   assign DETECT_RESET_OUT = st.det_reset;
   assign DETECT_ON_OUT    = st.det_on;
   assign WARN_LEVEL_OUT   = st.warn_lvl;
   assign DETECT_LEVEL_OUT = st.detect_voltage_select;
   assign BANDGAP_BUF_OUT  = st.bandgap_buffer_enable;
   assign PD_STOP_SEL_OUT  = st.power_down_control;
endmodule
`default_nettype wire

/* File: pwrc_assertions.sv */
// port-level checks for the power monitor block
`timescale 1ns/1ps
`default_nettype none
module pwrc_assertions
   import pwrc_pkg::*;
#(
   parameter int ADDR_W = 12                   // bus address width
) (
   input wire logic              CLK_IN,
   input wire logic              RST_IN,
   input wire logic [ADDR_W-1:0] S_AWADDR_IN,
   input wire logic              S_AWVALID_IN,
   input wire logic              S_AWREADY_OUT,
   input wire logic [31:0]       S_WDATA_IN,
   input wire logic [3:0]        S_WSTRB_IN,
   input wire logic              S_WVALID_IN,
   input wire logic              S_WREADY_OUT,
   input wire logic [1:0]        S_BRESP_OUT,
   input wire logic              S_BVALID_OUT,
   input wire logic              S_BREADY_IN,
   input wire logic [ADDR_W-1:0] S_ARADDR_IN,
   input wire logic              S_ARVALID_IN,
   input wire logic              S_ARREADY_OUT,
   input wire logic [31:0]       S_RDATA_OUT,
   input wire logic [1:0]        S_RRESP_OUT,
   input wire logic              S_RVALID_OUT,
   input wire logic              S_RREADY_IN,
   input wire logic              WARN_BELOW_IN,
   input wire logic              DETECT_BELOW_IN,
   input wire logic              STOP_ACTIVE_IN,
   input wire logic              PD_RECOVERED_IN,
   input wire logic              WARN_IRQ_OUT,
   input wire logic              DETECT_RESET_OUT,
   input wire logic              DETECT_ON_OUT,
   input wire logic [1:0]        WARN_LEVEL_OUT,
   input wire logic              DETECT_LEVEL_OUT,
   input wire logic              BANDGAP_BUF_OUT,
   input wire logic              PD_STOP_SEL_OUT
);
   // one clock domain, reset masks every check
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   // answers hold until the master takes them
   property p_b_hold; S_BVALID_OUT && !S_BREADY_IN |=> S_BVALID_OUT && $stable(S_BRESP_OUT); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer not held");
   property p_r_hold; S_RVALID_OUT && !S_RREADY_IN |=> S_RVALID_OUT && $stable(S_RDATA_OUT); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer not held");
   property p_r_upper; S_RVALID_OUT |-> S_RDATA_OUT[31:8] == 24'h0; endproperty
   a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
   // no new request taken while an answer waits
   property p_w_busy; S_BVALID_OUT |-> !S_AWREADY_OUT && !S_WREADY_OUT; endproperty
   a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
   property p_ar_busy; S_RVALID_OUT |-> !S_ARREADY_OUT; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
   // threshold code carries the detect select on top
   property p_lvl; WARN_LEVEL_OUT[1] == DETECT_LEVEL_OUT; endproperty
   a_lvl: assert property (p_lvl) else $error("level code mismatch");
   // reset request only from live detection
   property p_rst_on; DETECT_RESET_OUT |-> DETECT_ON_OUT; endproperty
   a_rst_on: assert property (p_rst_on) else $error("reset while detect off");
   // sync pipe is three deep, four quiet cycles clear it
   property p_rst_low; !DETECT_BELOW_IN [*4] |-> !DETECT_RESET_OUT; endproperty
   a_rst_low: assert property (p_rst_low) else $error("reset without detect");
   // stop mode select moves only with a write
   property p_pd_sel; $changed(PD_STOP_SEL_OUT) |-> S_BVALID_OUT || $past(S_BVALID_OUT); endproperty
   a_pd_sel: assert property (p_pd_sel) else $error("stop select moved");
endmodule
bind pwrc_top pwrc_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* File: pwrc_tb.sv */
// self-checking bench for the power monitor block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pwrc_pkg::*;
   // table row: write, read back, expected static outputs
   typedef struct {
      logic [11:0] a;
      logic [31:0] wd;
      logic [31:0] rd;
      logic [1:0]  lvl;
      logic        bg;
      logic        pd;
   } pwrc_row_t;
   logic        CLK_IN, RST_IN, WARN_BELOW_IN, DETECT_BELOW_IN, STOP_ACTIVE_IN, PD_RECOVERED_IN;
   logic [11:0] S_AWADDR_IN, S_ARADDR_IN;
   logic [31:0] S_WDATA_IN, S_RDATA_OUT;
   logic [3:0]  S_WSTRB_IN;
   logic [1:0]  S_BRESP_OUT, S_RRESP_OUT, WARN_LEVEL_OUT;
   logic        S_AWVALID_IN, S_WVALID_IN, S_BREADY_IN, S_ARVALID_IN, S_RREADY_IN;
   logic        S_AWREADY_OUT, S_WREADY_OUT, S_BVALID_OUT, S_ARREADY_OUT, S_RVALID_OUT;
   logic        WARN_IRQ_OUT, DETECT_RESET_OUT, DETECT_ON_OUT, DETECT_LEVEL_OUT;
   logic        BANDGAP_BUF_OUT, PD_STOP_SEL_OUT;
   int          n_errors = 0;
   int          checks = 0;
   // write-once bits lock on the first write, so row order matters
   pwrc_row_t   rows [7] = '{
      '{12'h000, 32'h3D, 32'h3D, 2'h0, 1'h1, 1'h0},
      '{12'h000, 32'h00, 32'h1C, 2'h0, 1'h0, 1'h0},
      '{12'h000, 32'hFF, 32'h3D, 2'h0, 1'h1, 1'h0},
      '{12'h004, 32'h31, 32'h31, 2'h3, 1'h1, 1'h1},
      '{12'h004, 32'h00, 32'h21, 2'h2, 1'h1, 1'h1},
      '{12'h004, 32'hFF, 32'h31, 2'h3, 1'h1, 1'h1},
      '{12'h008, 32'hFF, 32'h00, 2'h3, 1'h1, 1'h1}};

   pwrc_top #(.ADDR_W(12)) uut (.*);

   // 100 ns period
   always #50 CLK_IN = ~CLK_IN;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // unmapped places answer with an error code
   function automatic logic [1:0] resp_of(input logic [11:0] a);
      return (a == 12'h000 || a == 12'h004) ? 2'h0 : 2'h2;
   endfunction

   // handshakes sampled at the falling edge, released after the rising one
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_t, w_t, got;
      int   n;
      got = 1'b0;
      n = 0;
      @(posedge CLK_IN);
      S_AWADDR_IN  <= a;
      S_WDATA_IN   <= d;
      S_AWVALID_IN <= 1'h1;
      S_WVALID_IN  <= 1'h1;
      S_BREADY_IN  <= 1'h1;
      while (!got && n < 40) begin
         @(negedge CLK_IN);
         aw_t = S_AWVALID_IN && S_AWREADY_OUT;
         w_t  = S_WVALID_IN && S_WREADY_OUT;
         got  = S_BVALID_OUT;
         if (got) chk(32'(S_BRESP_OUT), 32'(resp_of(a)));
         n++;
         @(posedge CLK_IN);
         if (aw_t) S_AWVALID_IN <= 1'h0;
         if (w_t) S_WVALID_IN <= 1'h0;
      end
      S_BREADY_IN <= 1'h0;
      if (!got) n_errors++;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic ar_t, got;
      int   n;
      got = 1'b0;
      n = 0;
      @(posedge CLK_IN);
      S_ARADDR_IN  <= a;
      S_ARVALID_IN <= 1'h1;
      S_RREADY_IN  <= 1'h1;
      while (!got && n < 40) begin
         @(negedge CLK_IN);
         ar_t = S_ARVALID_IN && S_ARREADY_OUT;
         got  = S_RVALID_OUT;
         if (got) begin
            chk(S_RDATA_OUT, exp);
            chk(32'(S_RRESP_OUT), 32'(resp_of(a)));
         end
         n++;
         @(posedge CLK_IN);
         if (ar_t) S_ARVALID_IN <= 1'h0;
      end
      S_RREADY_IN <= 1'h0;
      if (!got) n_errors++;
   endtask

   task automatic do_reset();
      @(posedge CLK_IN);
      RST_IN <= 1'h1;
      repeat (4) @(posedge CLK_IN);
      RST_IN <= 1'h0;
   endtask

   // hang guard, far beyond the expected few hundred cycles
   initial begin
      repeat (5000) @(posedge CLK_IN);
      n_errors++;
      close_out();
   end

   initial begin
      CLK_IN = 1'h0;
      RST_IN = 1'h1;
      {S_AWADDR_IN, S_ARADDR_IN, S_WDATA_IN} = '0;
      {S_AWVALID_IN, S_WVALID_IN, S_BREADY_IN, S_ARVALID_IN, S_RREADY_IN} = '0;
      {WARN_BELOW_IN, DETECT_BELOW_IN, STOP_ACTIVE_IN, PD_RECOVERED_IN} = '0;
      S_WSTRB_IN = 4'hF;
      do_reset();
      rd(12'h000, 32'h1C);
      rd(12'h004, 32'h00);
      chk(32'(DETECT_ON_OUT), 32'h1);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].wd);
         rd(rows[i].a, rows[i].rd);
         chk(32'(WARN_LEVEL_OUT), 32'(rows[i].lvl));
         chk(32'(DETECT_LEVEL_OUT), 32'(rows[i].lvl[1]));
         chk(32'(BANDGAP_BUF_OUT), 32'(rows[i].bg));
         chk(32'(PD_STOP_SEL_OUT), 32'(rows[i].pd));
      end
      // warning flag: sticky, ack refused while low supply persists
      WARN_BELOW_IN <= 1'h1;
      repeat (5) @(posedge CLK_IN);
      rd(12'h000, 32'hBD);
      chk(32'(WARN_IRQ_OUT), 32'h1);
      wr(12'h000, 32'h7D);
      rd(12'h000, 32'hBD);
      WARN_BELOW_IN <= 1'h0;
      repeat (5) @(posedge CLK_IN);
      rd(12'h000, 32'hBD);
      wr(12'h000, 32'h1D);
      chk(32'(WARN_IRQ_OUT), 32'h0);
      wr(12'h000, 32'h7D);
      rd(12'h000, 32'h3D);
      chk(32'(WARN_IRQ_OUT), 32'h0);
      // detect with reset and stop enables set
      DETECT_BELOW_IN <= 1'h1;
      repeat (5) @(posedge CLK_IN);
      chk(32'(DETECT_RESET_OUT), 32'h1);
      STOP_ACTIVE_IN <= 1'h1;
      repeat (3) @(posedge CLK_IN);
      chk(32'(DETECT_ON_OUT), 32'h1);
      DETECT_BELOW_IN <= 1'h0;
      STOP_ACTIVE_IN <= 1'h0;
      repeat (5) @(posedge CLK_IN);
      chk(32'(DETECT_RESET_OUT), 32'h0);
      // recovery flag checked before its ack, as software must
      PD_RECOVERED_IN <= 1'h1;
      repeat (5) @(posedge CLK_IN);
      rd(12'h004, 32'h39);
      PD_RECOVERED_IN <= 1'h0;
      wr(12'h004, 32'h04);
      rd(12'h004, 32'h21);
      // second reset frees the locks; lower threshold pair
      do_reset();
      rd(12'h004, 32'h00);
      wr(12'h004, 32'h10);
      chk(32'(WARN_LEVEL_OUT), 32'h1);
      wr(12'h004, 32'h20);
      rd(12'h004, 32'h00);
      chk(32'(WARN_LEVEL_OUT), 32'h0);
      wr(12'h000, 32'h04);
      DETECT_BELOW_IN <= 1'h1;
      repeat (5) @(posedge CLK_IN);
      chk(32'(DETECT_RESET_OUT), 32'h0);
      STOP_ACTIVE_IN <= 1'h1;
      repeat (3) @(posedge CLK_IN);
      chk(32'(DETECT_ON_OUT), 32'h0);
      STOP_ACTIVE_IN <= 1'h0;
      DETECT_BELOW_IN <= 1'h0;
      // third reset: masked byte lane is ignored, then detect off
      // supply already low across reset must set the flag again
      WARN_BELOW_IN <= 1'h1;
      do_reset();
      S_WSTRB_IN <= 4'hE;
      wr(12'h000, 32'h00);
      S_WSTRB_IN <= 4'hF;
      rd(12'h000, 32'h9C);
      chk(32'(WARN_IRQ_OUT), 32'h0);
      wr(12'h000, 32'h18);
      DETECT_BELOW_IN <= 1'h1;
      repeat (5) @(posedge CLK_IN);
      chk(32'(DETECT_ON_OUT), 32'h0);
      chk(32'(DETECT_RESET_OUT), 32'h0);
      close_out();
   end
endmodule
`default_nettype wire
